// ### rtl/gp_defines.svh
// constants for the command driven general ports: command codes, reset values, counts
// assumes inclusion by the receiver and port core design files; definitions only
//
// Function
// - reset makes all four general lines inputs until a direction command or an enable command
// - enable command routes subcode sync and data onto third and fourth lines
// - disable command returns those lines to port use; disabled after reset
// - port read shifts lines 2,3,4,5 out, one per host shift clock fall
// - port read is a one-byte command without data byte
// - direction command takes low four data bits, lsb line 2, one is output
// - output command sets levels of output lines from low four data bits
// - any accepted command aborts track check, jump or motor brake
// - read pin driven only while chip select low, else high impedance
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

`define GP_CMD_PORT_READ 8'hDD
`define GP_CMD_PORT_DIR 8'hDB
`define GP_CMD_PORT_OUT 8'hDC
`define GP_CMD_SUB_ON 8'hF6
`define GP_CMD_SUB_OFF 8'hF7

`define GP_DIR_RESET 4'h0
`define GP_LEVEL_RESET 4'h0
`define GP_SUB_RESET 1'b0
`define GP_SYNC_IDX 2
`define GP_DATA_IDX 3
`define GP_READ_BITS 3'h4
`define GP_BYTE_LAST 3'h7

`endif

// ### rtl/gp_pkg.sv
// types shared by the command receiver and the general port core
// assumes gp_defines.svh is compiled alongside
package gp_pkg;

    typedef enum logic {READ_IDLE, READ_SHIFT} read_mode_t;

    // receiver state; fields 1 and 2 form the pin synchronisers
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic prev_clk;
        logic prev_latch;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic [7:0] cur_byte;
        logic [7:0] prev_byte;
        logic [1:0] nbytes;
        logic cmd_valid;
        logic data_valid;
        logic [7:0] cmd_byte;
        logic [7:0] data_byte;
        logic shift_fall;
    } rx_state_t;

    typedef struct packed {
        logic [3:0] gin1;
        logic [3:0] gin2;
        logic cs1;
        logic cs2;
        logic [3:0] dir;
        logic [3:0] level;
        logic sub_on;
        read_mode_t rd_mode;
        logic [3:0] rd_sh;
        logic [2:0] rd_cnt;
        logic [3:0] line_out;
        logic [3:0] line_oe_b;
        logic sro;
        logic sro_oe_b;
        logic abort;
    } port_state_t;

endpackage

// ### rtl/cmd_link_if.sv
// carries decoded commands and shift clock events from the receiver to the port core
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface cmd_link_if;
    logic cmd_valid;
    logic data_valid;
    logic [7:0] cmd_byte;
    logic [7:0] data_byte;
    logic shift_fall;
    modport rx (output cmd_valid, output data_valid, output cmd_byte, output data_byte, output shift_fall);
    modport core (input cmd_valid, input data_valid, input cmd_byte, input data_byte, input shift_fall);
endinterface
`default_nettype wire

// ### rtl/serial_cmd_rx.sv
// serial command receiver: samples shift clock, latch line and data, assembles bytes
// assumes the three link pins are asynchronous to core_clk and slow against it
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module serial_cmd_rx (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic host_shift_clock,
    input wire logic command_latch_line,
    input wire logic serial_command_in,
    cmd_link_if.rx link
);
    gp_pkg::rx_state_t s;
    gp_pkg::rx_state_t next_s;
    logic clk_s, latch_s, din_s;

    assign clk_s = s.sync2[2];
    assign latch_s = s.sync2[1];
    assign din_s = s.sync2[0];

    // byte assembly, lsb first; command taken when the latch line drops
    always_comb begin
        next_s = s;
        next_s.sync1 = {host_shift_clock, command_latch_line, serial_command_in};
        next_s.sync2 = s.sync1;
        next_s.prev_clk = clk_s;
        next_s.prev_latch = latch_s;
        next_s.cmd_valid = 1'b0;
        next_s.data_valid = 1'b0;
        next_s.shift_fall = s.prev_clk && !clk_s;
        if (latch_s && !s.prev_latch) begin
            next_s.bitcnt = 3'h0;
            next_s.nbytes = 2'h0;
        end else if (latch_s && clk_s && !s.prev_clk) begin
            next_s.shreg = {din_s, s.shreg[7:1]};
            next_s.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == `GP_BYTE_LAST) begin
                next_s.prev_byte = s.cur_byte;
                next_s.cur_byte = {din_s, s.shreg[7:1]};
                next_s.nbytes = (s.nbytes == 2'h2) ? 2'h2 : s.nbytes + 2'h1;
            end
        end else if (!latch_s && s.prev_latch && s.nbytes != 2'h0) begin
            // a lone byte is a one-byte command; a partial byte is dropped
            next_s.cmd_valid = 1'b1;
            next_s.cmd_byte = s.cur_byte;
            next_s.data_valid = (s.nbytes == 2'h2);
            next_s.data_byte = s.prev_byte;
            next_s.nbytes = 2'h0;
            next_s.bitcnt = 3'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= '0;
            s.sync1[2] <= 1'b1; // shift clock idles high, so no false edge follows reset
            s.sync2[2] <= 1'b1;
            s.prev_clk <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.cmd_valid = s.cmd_valid;
    assign link.data_valid = s.data_valid;
    assign link.cmd_byte = s.cmd_byte;
    assign link.data_byte = s.data_byte;
    assign link.shift_fall = s.shift_fall;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    cmd_one_cycle_a: assert property (s.cmd_valid |=> !s.cmd_valid)
        else $error("command strobe longer than one cycle");
endmodule
`default_nettype wire

// ### rtl/command_driven_general_ports.sv
// four general purpose lines set and read by serial commands, two shared with subcode outputs
// assumes host pins are asynchronous; subcode inputs come from logic on core_clk
// each pad gets a level and an active low enable; the pad ring resolves the line
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module command_driven_general_ports #(
    parameter int N_LINES = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic host_shift_clock,
    input wire logic command_latch_line,
    input wire logic serial_command_in,
    input wire logic chip_select_b,
    input wire logic two_byte_latch_condition,
    input wire logic [3:0] general_line_in,
    input wire logic subcode_frame_sync_out,
    input wire logic subcode_data_out,
    output logic [3:0] general_line_out,
    output logic [3:0] general_line_oe_b,
    output logic serial_read_out,
    output logic serial_read_oe_b,
    output logic subcode_route_enabled,
    output logic command_abort
);
    if (N_LINES != 4) begin : g_check
        $error("only four general lines are supported");
    end

    cmd_link_if link ();
    gp_pkg::port_state_t s;
    gp_pkg::port_state_t next_s;

    serial_cmd_rx u_rx (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .host_shift_clock(host_shift_clock),
        .command_latch_line(command_latch_line),
        .serial_command_in(serial_command_in),
        .link(link.rx)
    );

    // line drive: subcode signals take over the shared lines when routed
    function automatic logic [3:0] line_drive(input logic [3:0] level, input logic sub_on,
                                              input logic sync_v, input logic data_v);
        logic [3:0] v;
        v = level;
        if (sub_on) begin
            v[`GP_SYNC_IDX] = sync_v;
            v[`GP_DATA_IDX] = data_v;
        end
        return v;
    endfunction

    // command decode, read shifter and output staging
    always_comb begin
        next_s = s;
        next_s.gin1 = general_line_in;
        next_s.gin2 = s.gin1;
        next_s.cs1 = chip_select_b;
        next_s.cs2 = s.cs1;
        next_s.abort = 1'b0;
        if (link.cmd_valid) begin
            next_s.abort = 1'b1;
            case (link.cmd_byte)
                `GP_CMD_PORT_READ: begin
                    next_s.rd_mode = gp_pkg::READ_SHIFT;
                    next_s.rd_sh = s.gin2;
                    next_s.rd_cnt = `GP_READ_BITS;
                end
                `GP_CMD_PORT_DIR: begin
                    if (link.data_valid && two_byte_latch_condition) begin
                        next_s.dir = link.data_byte[3:0];
                    end
                end
                `GP_CMD_PORT_OUT: begin
                    if (link.data_valid && two_byte_latch_condition) begin
                        next_s.level = link.data_byte[3:0];
                    end
                end
                `GP_CMD_SUB_ON: next_s.sub_on = 1'b1;
                `GP_CMD_SUB_OFF: next_s.sub_on = 1'b0;
                default: next_s.rd_mode = s.rd_mode;
            endcase
        end else if (s.rd_mode == gp_pkg::READ_SHIFT && link.shift_fall && !s.cs2) begin
            // falling shift clock edges one to three present the next line; the fourth ends the read
            if (s.rd_cnt == 3'h1) begin
                next_s.rd_mode = gp_pkg::READ_IDLE;
            end else begin
                next_s.rd_sh = {1'b0, s.rd_sh[3:1]};
                next_s.rd_cnt = s.rd_cnt - 3'h1;
            end
        end
        // outputs staged from next values, the read pin enable from the current cs2, so every port leaves a flip-flop
        next_s.line_out = line_drive(next_s.level, next_s.sub_on, subcode_frame_sync_out, subcode_data_out);
        next_s.line_oe_b = ~(next_s.dir | (next_s.sub_on ? 4'hC : 4'h0));
        next_s.sro = (next_s.rd_mode == gp_pkg::READ_SHIFT) ? next_s.rd_sh[0] : 1'b0;
        next_s.sro_oe_b = s.cs2;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= '0;
            s.dir <= `GP_DIR_RESET;
            s.level <= `GP_LEVEL_RESET;
            s.sub_on <= `GP_SUB_RESET;
            s.rd_mode <= gp_pkg::READ_IDLE;
            s.line_oe_b <= 4'hF;
            s.sro_oe_b <= 1'b1;
            s.cs1 <= 1'b1; // deselected, so the read pin stays released after reset
            s.cs2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign general_line_out = s.line_out;
    assign general_line_oe_b = s.line_oe_b;
    assign serial_read_out = s.sro;
    assign serial_read_oe_b = s.sro_oe_b;
    assign subcode_route_enabled = s.sub_on;
    assign command_abort = s.abort;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence cmd_is(logic [7:0] code);
        link.cmd_valid && link.cmd_byte == code;
    endsequence
    sequence two_byte_cmd(logic [7:0] code);
        cmd_is(code) ##0 link.data_valid && two_byte_latch_condition;
    endsequence
    // a command that no decoder branch recognises
    sequence unknown_cmd;
        link.cmd_valid && link.cmd_byte != `GP_CMD_PORT_READ && link.cmd_byte != `GP_CMD_PORT_DIR
            && link.cmd_byte != `GP_CMD_PORT_OUT && link.cmd_byte != `GP_CMD_SUB_ON
            && link.cmd_byte != `GP_CMD_SUB_OFF;
    endsequence
    // a two-byte code that came without its data byte or with the latch condition low
    sequence two_byte_refused(logic [7:0] code);
        cmd_is(code) ##0 !(link.data_valid && two_byte_latch_condition);
    endsequence
    // a shift clock fall that the read logic acts on; a command in the same cycle wins
    sequence read_step;
        s.rd_mode == gp_pkg::READ_SHIFT && link.shift_fall && !s.cs2 && !link.cmd_valid;
    endsequence
    // a shift clock fall seen while deselected, which must not move the read on
    sequence read_blocked;
        s.rd_mode == gp_pkg::READ_SHIFT && link.shift_fall && s.cs2 && !link.cmd_valid;
    endsequence
    // a cycle with no command strobe: every stored setting must hold
    sequence quiet_cycle;
        !link.cmd_valid;
    endsequence

    reset_inputs_a: assert property (!$past(rst_b) |-> general_line_oe_b == 4'hF)
        else $error("lines not inputs after reset");
    subcode_on_a: assert property (cmd_is(`GP_CMD_SUB_ON)
                                   |=> subcode_route_enabled && general_line_oe_b[3:2] == 2'h0)
        else $error("subcode routing not enabled");
    subcode_off_a: assert property (cmd_is(`GP_CMD_SUB_OFF) |=> !subcode_route_enabled)
        else $error("subcode routing not disabled");
    read_first_bit_a: assert property (cmd_is(`GP_CMD_PORT_READ) |=> serial_read_out == $past(s.gin2[0]))
        else $error("read pin not showing first line");
    dir_set_a: assert property (two_byte_cmd(`GP_CMD_PORT_DIR) ##0 !s.sub_on
                                |=> general_line_oe_b == ~$past(link.data_byte[3:0]))
        else $error("direction not taken from data byte");
    level_set_a: assert property (two_byte_cmd(`GP_CMD_PORT_OUT) ##0 !s.sub_on
                                  |=> general_line_out == $past(link.data_byte[3:0]))
        else $error("output level not taken from data byte");
    level_kept_a: assert property (two_byte_cmd(`GP_CMD_PORT_DIR) ##0 !s.sub_on
                                   |=> general_line_out == $past(s.level))
        else $error("direction change disturbed levels");
    abort_pulse_a: assert property (link.cmd_valid |=> command_abort ##1 !command_abort || link.cmd_valid)
        else $error("abort not pulsed on command");
    read_hiz_a: assert property (chip_select_b [*3] |=> serial_read_oe_b)
        else $error("read pin driven while deselected");
    // chip select and reset
    read_driven_a: assert property (!chip_select_b [*3] |=> !serial_read_oe_b)
        else $error("read pin not driven while selected");
    reset_quiet_a: assert property (!$past(rst_b)
                                    |-> !subcode_route_enabled && serial_read_oe_b && !command_abort)
        else $error("outputs not quiet after reset");
    // command strobes and what they leave behind
    no_abort_a: assert property (quiet_cycle |=> !command_abort)
        else $error("abort pulse without a command");
    settings_held_a: assert property (quiet_cycle
                                      |=> $stable(s.dir) && $stable(s.level) && $stable(s.sub_on))
        else $error("port settings changed without a command");
    oe_held_a: assert property (quiet_cycle |=> $stable(general_line_oe_b))
        else $error("line directions changed without a command");
    unknown_ignored_a: assert property (unknown_cmd
                                        |=> $stable(s.dir) && $stable(s.level) && $stable(s.sub_on))
        else $error("unknown command changed port settings");
    dir_refused_a: assert property (two_byte_refused(`GP_CMD_PORT_DIR) |=> $stable(s.dir))
        else $error("direction taken without its data byte");
    level_refused_a: assert property (two_byte_refused(`GP_CMD_PORT_OUT) |=> $stable(s.level))
        else $error("level taken without its data byte");
    route_kept_a: assert property (cmd_is(`GP_CMD_SUB_ON) |=> $stable(s.dir) && $stable(s.level))
        else $error("routing disturbed stored settings");
    port_back_a: assert property (cmd_is(`GP_CMD_SUB_OFF) |=> general_line_oe_b == ~$past(s.dir))
        else $error("shared lines not returned to port use");
    // line drive while nothing is being commanded
    port_lines_a: assert property (quiet_cycle ##0 !s.sub_on |=> general_line_out == $past(s.level))
        else $error("line levels differ from stored levels");
    sub_lines_a: assert property (quiet_cycle ##0 s.sub_on
                                  |=> general_line_out[2] == $past(subcode_frame_sync_out)
                                      && general_line_out[3] == $past(subcode_data_out))
        else $error("shared lines not carrying subcode signals");
    sub_driven_a: assert property (quiet_cycle ##0 s.sub_on |=> general_line_oe_b[3:2] == 2'h0)
        else $error("shared lines not driven while routed");
    // read shifter steps
    read_start_a: assert property (cmd_is(`GP_CMD_PORT_READ)
                                   |=> s.rd_mode == gp_pkg::READ_SHIFT && s.rd_cnt == `GP_READ_BITS)
        else $error("port read did not start");
    read_advance_a: assert property (read_step ##0 s.rd_cnt != 3'h1 |=> serial_read_out == $past(s.rd_sh[1]))
        else $error("read pin did not move to the next line");
    read_done_a: assert property (read_step ##0 s.rd_cnt == 3'h1
                                  |=> s.rd_mode == gp_pkg::READ_IDLE && !serial_read_out)
        else $error("read did not end after the fourth line");
    read_blocked_a: assert property (read_blocked |=> $stable(s.rd_sh) && $stable(s.rd_cnt))
        else $error("read moved on while deselected");
    read_quiet_a: assert property (quiet_cycle ##0 s.rd_mode == gp_pkg::READ_IDLE |=> !serial_read_out)
        else $error("read pin not low outside a read");
endmodule
`default_nettype wire

// ### tb/host_mcu_model.sv
// host microcontroller model: shifts commands in and port bits out over the serial link
// assumes the device samples these pins with its own faster clock
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    output logic host_shift_clock,
    output logic command_latch_line,
    output logic serial_command_in,
    output logic chip_select_b,
    input wire logic serial_read_out,
    input wire logic serial_read_oe_b
);
    // shift clock idles high and stands still between frames
    initial begin
        host_shift_clock = 1'b1;
        command_latch_line = 1'b0;
        serial_command_in = 1'b0;
        chip_select_b = 1'b1;
    end

    // lsb first; data changes while the clock is low, taken on its rise
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            host_shift_clock = 1'b0;
            serial_command_in = b[i];
            #80 host_shift_clock = 1'b1;
            #80;
        end
    endtask

    // whole command in one latch-high period, data byte ahead of the command
    task automatic send(input logic [7:0] d, input logic [7:0] c, input bit two);
        #2; // step off the core clock edge at which the caller may stand
        command_latch_line = 1'b1;
        #83;
        if (two) begin
            send_byte(d);
        end
        send_byte(c);
        command_latch_line = 1'b0;
        serial_command_in = ~serial_command_in; // idle value must not look like the last bit
        #500;
    endtask

    // each bit is read before the falling edge that moves on to the next line
    task automatic read4(output logic [3:0] q, output logic oe_seen);
        chip_select_b = 1'b0;
        #300;
        oe_seen = serial_read_oe_b;
        for (int i = 0; i < 4; i++) begin
            q[i] = serial_read_out;
            host_shift_clock = 1'b0;
            #80 host_shift_clock = 1'b1;
            #80;
        end
        chip_select_b = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// ### tb/command_driven_general_ports_tb.sv
// self-checking bench for the command driven general ports
// assumes the host model drives the link; pins are resolved here from both drivers
`timescale 1ns/1ps
`default_nettype none
module command_driven_general_ports_tb;
    logic core_clk = 1'b0, rst_b = 1'b0, tblc = 1'b1, sfs = 1'b0, sdo = 1'b0;
    logic [3:0] ext = 4'h0, lout, oe_b, pin, dir = 4'h0, lvl = 4'h0, q;
    logic sclk, latch, din, cs_b, sro, sro_oe_b, route, abort, oe_seen;
    logic [31:0] v;
    int errors = 0, tests_run = 0, seed = 9575, aborts = 0, cycles = 0;

    always #5 core_clk = ~core_clk;
    // a line shows the device's level while driven, else the outside level
    assign pin = (oe_b & ext) | (~oe_b & lout);

    host_mcu_model host_u (.host_shift_clock(sclk), .command_latch_line(latch), .serial_command_in(din),
        .chip_select_b(cs_b), .serial_read_out(sro), .serial_read_oe_b(sro_oe_b));
    command_driven_general_ports dut_u (.core_clk(core_clk), .rst_b(rst_b), .host_shift_clock(sclk),
        .command_latch_line(latch), .serial_command_in(din), .chip_select_b(cs_b),
        .two_byte_latch_condition(tblc), .general_line_in(pin), .subcode_frame_sync_out(sfs),
        .subcode_data_out(sdo), .general_line_out(lout), .general_line_oe_b(oe_b),
        .serial_read_out(sro), .serial_read_oe_b(sro_oe_b), .subcode_route_enabled(route),
        .command_abort(abort));

    // abort pulse counter and hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (abort === 1'b1) aborts <= aborts + 1;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // routed lines are always driven, whatever their direction
    function automatic logic [3:0] exp_oe(input logic [3:0] d, input logic r);
        exp_oe = r ? {2'b00, ~d[1:0]} : ~d;
    endfunction

    // every command, refused or not, gives one abort pulse
    task automatic cmd(input logic [7:0] d, input logic [7:0] c, input bit two);
        int a0;
        a0 = aborts;
        host_u.send(d, c, two);
        check("abort_count", 8'(aborts - a0), 8'h01);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
        check("oe_reset", {4'h0, oe_b}, 8'h0F);
        check("route_reset", {7'h0, route}, 8'h00);
        check("read_oe_reset", {7'h0, sro_oe_b}, 8'h01);
        // level first, then direction, so held levels show once lines turn output
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 32'h0000FFF5 : $random(seed);
            @(posedge core_clk) ext <= v[19:16];
            cmd(v[7:0], 8'hDC, 1'b1);
            lvl = v[3:0];
            cmd(v[15:8], 8'hDB, 1'b1);
            dir = v[11:8];
            check("dir_oe", {4'h0, oe_b}, {4'h0, exp_oe(dir, 1'b0)});
            check("level", {4'h0, lout & dir}, {4'h0, lvl & dir});
        end
        // refused: latch condition low, then a direction command without data
        @(posedge core_clk) tblc <= 1'b0;
        cmd({4'h0, ~dir}, 8'hDB, 1'b1);
        @(posedge core_clk) tblc <= 1'b1;
        cmd(8'h00, 8'hDB, 1'b0);
        check("dir_refused", {4'h0, oe_b}, {4'h0, ~dir});
        cmd(8'h00, 8'hF6, 1'b0);
        check("route_on", {7'h0, route}, 8'h01);
        check("route_oe", {4'h0, oe_b}, {4'h0, exp_oe(dir, 1'b1)});
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk) {sdo, sfs} <= k[1:0];
            repeat (3) @(posedge core_clk);
            #1 check("sub_lines", {6'h0, lout[3:2]}, {6'h0, k[1:0]});
        end
        cmd(8'h00, 8'hF7, 1'b0);
        check("route_off", {7'h0, route}, 8'h00);
        check("port_back", {4'h0, oe_b}, {4'h0, ~dir});
        // a code the port logic does not know only pulses abort
        cmd(8'h00, 8'h28, 1'b0);
        check("unknown_oe", {4'h0, oe_b}, {4'h0, ~dir});
        // port read with a fresh outside pattern each time
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk) ext <= (k == 0) ? 4'hA : 4'($random(seed));
            cmd(8'h00, 8'hDD, 1'b0);
            host_u.read4(q, oe_seen);
            check("read_bits", {4'h0, q}, {4'h0, (dir & lvl) | (~dir & ext)});
            check("read_oe", {7'h0, oe_seen}, 8'h00);
            check("read_idle", {7'h0, sro_oe_b}, 8'h01);
            check("read_end", {7'h0, sro}, 8'h00);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
